// ==== core/phy_line_coding_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - manchester cell, inverted half then true half
// - append idle start marker after 10M packet
// - 10M encodes only packet data, gap left silent
// - decode 5-bit words to nibbles, forward them
// - start delimiter pair becomes two 0101 nibbles
// - end delimiter pair becomes two 0000 nibbles
// - unused codes decode 0000, encoder default sends 11101
// - rx error flagged with the affected nibbles
// - delimiter and code errors set status flags
// - 10M rx gives NRZ, idle marker bits assembled like data
// - no valid line, recovery tracks local reference
// - 100M switch needs squelch and settled equalizer
// - 100M recovered clock is rx code bit clock divided by four
// - sample bits, assemble nibbles at both speeds
// - 10M 2.5 MHz clock, switch on squelch
// - 10M lock skips 12 bits, keeps every later nibble
// - scramble and descramble only in 100M mode
// - bypass sends encoder output straight to line
// - bypass feeds received bits straight to decoder
// - descrambler output aligned to code boundaries
// - 25 idle ones per 1ms or resync
// - loss flag held until sync regained
// - 100M delimiters replace preamble, end, idles
module phy_line_coding_datapath #(
  parameter int unsigned SYNC_WINDOW_CYCLES =
    phy_line_coding_pkg::SYNC_WINDOW_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [phy_line_coding_pkg::ADDR_W-1:0] i_addr,
  input wire logic [phy_line_coding_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [phy_line_coding_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_tx_en,
  input wire logic [3:0] i_txd,
  output logic o_tx_req,
  output logic o_transmit_ref_clock,
  output logic o_line_tx,
  output logic o_line_tx_en,
  input wire logic i_line_rx_clk,
  input wire logic i_line_rx_bit,
  input wire logic i_squelch_ok,
  input wire logic i_eq_settled,
  output logic o_cdr_on_line,
  output logic o_recovered_rx_clock,
  output phy_line_coding_pkg::rx_nib_t o_rx
);
  import phy_line_coding_pkg::*;

  if (SYNC_WINDOW_CYCLES < 64 || SYNC_WINDOW_CYCLES > 1000000)
  begin : g_bad_window
    $error("sync window length out of range");
  end

  // ==========================================================
  // code tables
  function automatic logic [4:0] enc5(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h1E;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction : enc5

  // returns {is_data, nibble}; anything else yields 0000
  function automatic logic [4:0] dec5(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc5(4'(i)) == c) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : dec5

  localparam logic [16:0] ACC_STEP = 17'(CLK_PERIOD_PS);
  localparam logic [16:0] ACC_MOD = 17'(HALF_BIT_PS);
  localparam logic [19:0] WD_LAST = 20'(SYNC_WINDOW_CYCLES - 1);

  // ==========================================================
  // register port
  logic [1:0] cfg_ff;
  logic [2:0] err_ff;
  logic [2:0] err_set_ff;
  logic sync_ok;
  logic cdr_on_line_ff;
  wire speed100 = cfg_ff[CFG_SPEED_POS];
  wire bypass = cfg_ff[CFG_BYPASS_POS];
  wire [2:0] err_clr = (i_wr && i_addr == STAT_ADDR) ? i_wdata[2:0] : 3'h0;

  // configuration register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= CFG_RESET;
    end else if (i_wr && i_addr == CFG_ADDR) begin
      cfg_ff <= i_wdata[1:0];
    end
  end

  // sticky error flags, write one to clear; a new error beats the clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      err_ff <= 3'h0;
    end else begin
      err_ff <= (err_ff & ~err_clr) | err_set_ff;
    end
  end

  // read data lives only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd && i_addr == CFG_ADDR) begin
      o_rdata <= {30'h0, cfg_ff};
    end else if (i_rd && i_addr == STAT_ADDR) begin
      o_rdata <= {27'h0, cdr_on_line_ff, ~sync_ok, err_ff};
    end else begin
      o_rdata <= '0;
    end
  end

  // ==========================================================
  // transmit timing: 100M one code bit per clock, 10M half-bit ticks
  logic [2:0] bit_cnt_ff;
  logic [15:0] acc_ff;
  logic half_ff;
  logic [1:0] tbit_ff;
  wire [16:0] acc_sum = {1'b0, acc_ff} + ACC_STEP;
  wire half_stb = acc_sum >= ACC_MOD;
  wire bit_stb = half_stb && half_ff;
  wire code_stb = bit_cnt_ff == 3'h4;
  wire nib10_stb = bit_stb && tbit_ff == 2'h3;

  // 10M half-bit averages 6.25 clocks via a fractional accumulator
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt_ff <= 3'h0;
      acc_ff <= 16'h0;
      half_ff <= 1'b0;
      tbit_ff <= 2'h0;
      o_transmit_ref_clock <= 1'b0;
    end else begin
      bit_cnt_ff <= code_stb ? 3'h0 : bit_cnt_ff + 3'h1;
      acc_ff <= half_stb ? 16'(acc_sum - ACC_MOD) : acc_sum[15:0];
      if (half_stb) begin
        half_ff <= ~half_ff;
      end
      if (bit_stb) begin
        tbit_ff <= tbit_ff + 2'h1;
      end
      o_transmit_ref_clock <= speed100 ? (bit_cnt_ff < 3'h2) :
                                         (tbit_ff < 2'h2);
    end
  end

  assign o_tx_req = speed100 ? code_stb : nib10_stb;

  // ==========================================================
  // 100M encoder and scrambler
  tx_st_t t_st_ff;
  logic [4:0] txsh_ff;
  logic [10:0] scr_ff;
  wire skey = scr_ff[10] ^ scr_ff[8];

  // code words go out msb first; delimiters frame each packet
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      t_st_ff <= T_IDLE;
      txsh_ff <= CODE_I;
    end else if (code_stb) begin
      case (t_st_ff)
        T_IDLE: begin
          txsh_ff <= i_tx_en ? CODE_J : CODE_I;
          t_st_ff <= i_tx_en ? T_SEND_K : T_IDLE;
        end
        T_SEND_K: begin
          txsh_ff <= CODE_K;
          t_st_ff <= T_DATA;
        end
        T_DATA: begin
          txsh_ff <= i_tx_en ? enc5(i_txd) : CODE_T;
          t_st_ff <= i_tx_en ? T_DATA : T_SEND_R;
        end
        T_SEND_R: begin
          txsh_ff <= CODE_R;
          t_st_ff <= T_IDLE;
        end
        default: begin
          txsh_ff <= CODE_I;
          t_st_ff <= T_IDLE;
        end
      endcase
    end else begin
      txsh_ff <= {txsh_ff[3:0], 1'b0};
    end
  end

  // free-running 11-bit key stream, x^11 + x^9 + 1
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scr_ff <= SCR_SEED;
    end else if (speed100) begin
      scr_ff <= {scr_ff[9:0], skey};
    end
  end

  // ==========================================================
  // 10M manchester encoder
  man_st_t m_st_ff;
  logic [3:0] mnib_ff;
  logic [2:0] mark_cnt_ff;
  wire mbit = mnib_ff[tbit_ff];

  // a packet ends with the idle start marker, then the line goes quiet
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      m_st_ff <= M_IDLE;
      mnib_ff <= 4'h0;
      mark_cnt_ff <= 3'h0;
    end else if (nib10_stb && m_st_ff != M_MARK) begin
      if (i_tx_en) begin
        mnib_ff <= i_txd;
        m_st_ff <= M_DATA;
      end else if (m_st_ff == M_DATA) begin
        m_st_ff <= M_MARK;
        mark_cnt_ff <= 3'(MARK_HALVES);
      end
    end else if (m_st_ff == M_MARK && half_stb) begin
      mark_cnt_ff <= mark_cnt_ff - 3'h1;
      if (mark_cnt_ff == 3'h1) begin
        m_st_ff <= M_IDLE;
      end
    end
  end

  // line output, registered
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_line_tx <= 1'b0;
      o_line_tx_en <= 1'b0;
    end else if (speed100) begin
      o_line_tx <= bypass ? txsh_ff[4] : txsh_ff[4] ^ skey;
      o_line_tx_en <= 1'b1;
    end else begin
      case (m_st_ff)
        M_DATA: begin
          o_line_tx <= half_ff ? mbit : ~mbit;
          o_line_tx_en <= 1'b1;
        end
        M_MARK: begin
          o_line_tx <= 1'b1;
          o_line_tx_en <= 1'b1;
        end
        default: begin
          o_line_tx <= 1'b0;
          o_line_tx_en <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // line inputs: two flops each, a third only for the clock edge
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic rclk_d_ff;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      rclk_d_ff <= 1'b0;
    end else begin
      s1_ff <= {i_eq_settled, i_squelch_ok, i_line_rx_bit, i_line_rx_clk};
      s2_ff <= s1_ff;
      rclk_d_ff <= s2_ff[0];
    end
  end
  wire rx_rise = s2_ff[0] && !rclk_d_ff;
  wire rbit = s2_ff[1];
  wire squelch_s = s2_ff[2];
  wire eq_s = s2_ff[3];

  // ==========================================================
  // clock recovery reference select and recovered nibble clock
  logic [1:0] rcnt_ff;
  logic line_d_ff;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cdr_on_line_ff <= 1'b0;
      line_d_ff <= 1'b0;
      rcnt_ff <= 2'h0;
      o_recovered_rx_clock <= 1'b0;
    end else begin
      cdr_on_line_ff <= squelch_s && (!speed100 || eq_s);
      line_d_ff <= cdr_on_line_ff;
      if (rx_rise && cdr_on_line_ff) begin
        rcnt_ff <= rcnt_ff + 2'h1;
      end
      // one cycle per four rx bits: 2.5 MHz at 10M, a quarter of the code bit rate at 100M
      o_recovered_rx_clock <= cdr_on_line_ff ? rcnt_ff[1] :
                                               o_transmit_ref_clock;
    end
  end
  assign o_cdr_on_line = cdr_on_line_ff;
  wire rx100_bit = rx_rise && cdr_on_line_ff && speed100;

  // ==========================================================
  // descrambler: key guessed from idle ones, then checked
  dsync_t dsync_ff;
  logic [10:0] dscr_ff;
  logic [4:0] acq_ff;
  logic [19:0] wd_ff;
  logic [4:0] run_ff;
  wire dkey = dscr_ff[10] ^ dscr_ff[8];
  wire plain = bypass ? rbit : rbit ^ dkey;
  wire wd_expire = wd_ff == WD_LAST;
  assign sync_ok = bypass || dsync_ff == D_SYNC;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dsync_ff <= D_LOAD;
      dscr_ff <= SCR_SEED;
      acq_ff <= 5'h0;
    end else if (!cdr_on_line_ff || !speed100 || bypass ||
                 (dsync_ff == D_SYNC && wd_expire)) begin
      dsync_ff <= D_LOAD;
      acq_ff <= 5'h0;
    end else if (rx_rise) begin
      case (dsync_ff)
        D_LOAD: begin
          dscr_ff <= {dscr_ff[9:0], ~rbit};
          acq_ff <= (acq_ff == 5'h0A) ? 5'h0 : acq_ff + 5'h1;
          if (acq_ff == 5'h0A) begin
            dsync_ff <= D_CHECK;
          end
        end
        D_CHECK: begin
          dscr_ff <= {dscr_ff[9:0], dkey};
          acq_ff <= acq_ff + 5'h1;
          if (!plain) begin
            dsync_ff <= D_LOAD;
            acq_ff <= 5'h0;
          end else if (acq_ff == 5'(ACQ_ONES - 1)) begin
            dsync_ff <= D_SYNC;
          end
        end
        D_SYNC: begin
          dscr_ff <= {dscr_ff[9:0], dkey};
        end
        default: begin
          dsync_ff <= D_LOAD;
        end
      endcase
    end
  end

  // watchdog: a run of idle ones restarts the window
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_ff <= 20'h0;
      run_ff <= 5'h0;
    end else if (dsync_ff != D_SYNC) begin
      wd_ff <= 20'h0;
      run_ff <= 5'h0;
    end else begin
      if (rx_rise && plain && run_ff == 5'(IDLE_ONES_MIN - 1)) begin
        wd_ff <= 20'h0;
      end else begin
        wd_ff <= wd_expire ? 20'h0 : wd_ff + 20'h1;
      end
      if (rx_rise) begin
        run_ff <= !plain ? 5'h0 :
                  (run_ff == 5'(IDLE_ONES_MIN)) ? run_ff : run_ff + 5'h1;
      end
    end
  end

  // ==========================================================
  // nibble assembly, both speeds
  frame_t fr_ff;
  logic [4:0] pshr_ff;
  logic [2:0] pos_ff;
  logic [3:0] skip_ff;
  logic [3:0] nib10_ff;
  logic [1:0] cnt10_ff;
  wire [4:0] code_now = {pshr_ff[3:0], plain};
  wire [4:0] dec_now = dec5(code_now);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fr_ff <= F_IDLE;
      pshr_ff <= CODE_I;
      pos_ff <= 3'h0;
      skip_ff <= 4'h0;
      nib10_ff <= 4'h0;
      cnt10_ff <= 2'h0;
      o_rx <= '0;
      err_set_ff <= 3'h0;
    end else begin
      err_set_ff <= 3'h0;
      if (!cdr_on_line_ff || (speed100 && !sync_ok)) begin
        fr_ff <= F_IDLE;
        o_rx <= '0;
        cnt10_ff <= 2'h0;
      end else if (!speed100) begin
        if (!line_d_ff) begin
          skip_ff <= 4'(LOCK_BITS);
        end else if (rx_rise && skip_ff != 4'h0) begin
          skip_ff <= skip_ff - 4'h1;
        end else if (rx_rise) begin
          nib10_ff <= {rbit, nib10_ff[3:1]};
          cnt10_ff <= cnt10_ff + 2'h1;
          if (cnt10_ff == 2'h3) begin
            o_rx <= '{dv: 1'b1, er: 1'b0, d: {rbit, nib10_ff[3:1]}};
          end
        end
      end else if (rx_rise) begin
        pshr_ff <= code_now;
        pos_ff <= (pos_ff == 3'h4) ? 3'h0 : pos_ff + 3'h1;
        if (fr_ff == F_IDLE && code_now == CODE_J) begin
          fr_ff <= F_EXP_K;
          pos_ff <= 3'h0;
          o_rx <= '{dv: 1'b1, er: 1'b0, d: NIB_PRE};
        end else if (fr_ff == F_IDLE && pos_ff == 3'h4) begin
          o_rx <= '0;
        end else if (pos_ff == 3'h4) begin
          case (fr_ff)
            F_EXP_K: begin
              fr_ff <= (code_now == CODE_K) ? F_DATA : F_IDLE;
              o_rx <= '{dv: 1'b1, er: code_now != CODE_K, d: NIB_PRE};
              err_set_ff[ST_START_POS] <= code_now != CODE_K;
            end
            F_DATA: begin
              if (code_now == CODE_T) begin
                fr_ff <= F_EXP_R;
                o_rx <= '{dv: 1'b1, er: 1'b0, d: NIB_ZERO};
              end else if (code_now == CODE_I) begin
                fr_ff <= F_IDLE;
                o_rx <= '{dv: 1'b1, er: 1'b1, d: NIB_ZERO};
                err_set_ff[ST_END_POS] <= 1'b1;
              end else begin
                // halt and unused codes give 0000 and flag an error
                o_rx <= '{dv: 1'b1, er: !dec_now[4], d: dec_now[3:0]};
                err_set_ff[ST_CODE_POS] <= !dec_now[4];
              end
            end
            F_EXP_R: begin
              fr_ff <= F_IDLE;
              o_rx <= '{dv: 1'b1, er: code_now != CODE_R, d: NIB_ZERO};
              err_set_ff[ST_END_POS] <= code_now != CODE_R;
            end
            default: begin
              fr_ff <= F_IDLE;
              o_rx <= '0;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_jk_sent;
    (txsh_ff == CODE_J) ##5 (txsh_ff == CODE_K);
  endsequence
  sequence s_tr_sent;
    (txsh_ff == CODE_T) ##5 (txsh_ff == CODE_R);
  endsequence

  a_tx_start_pair: assert property (
    (speed100 && code_stb && t_st_ff == T_IDLE && i_tx_en) |=> s_jk_sent)
    else $error("start delimiter pair not sent");
  a_tx_end_pair: assert property (
    (speed100 && code_stb && t_st_ff == T_DATA && !i_tx_en) |=> s_tr_sent)
    else $error("end delimiter pair not sent");
  a_manch_mid: assert property (
    (!speed100 && m_st_ff == M_DATA && half_stb && !half_ff &&
     !nib10_stb) |=> ##1 $changed(o_line_tx))
    else $error("no mid cell transition");
  a_marker_follows: assert property (
    (!speed100 && nib10_stb && m_st_ff == M_DATA && !i_tx_en)
    |=> ##1 (o_line_tx && o_line_tx_en))
    else $error("idle start marker missing");
  a_gap_silent: assert property (
    (!speed100 && m_st_ff == M_IDLE) |=> !o_line_tx_en)
    else $error("gap is driven");
  a_cdr_gate: assert property (
    (speed100 && !eq_s) |=> !o_cdr_on_line)
    else $error("loop switched before equalizer settled");
  a_ssd_replace: assert property (
    (rx100_bit && sync_ok && fr_ff == F_IDLE && code_now == CODE_J)
    |=> (o_rx.dv && o_rx.d == NIB_PRE && !o_rx.er))
    else $error("start delimiter not replaced");
  a_bad_k_err: assert property (
    (rx100_bit && sync_ok && fr_ff == F_EXP_K && pos_ff == 3'h4 &&
     code_now != CODE_K) |=> (o_rx.er ##1 err_ff[ST_START_POS]))
    else $error("start delimiter error not flagged");
  a_wd_loss: assert property (
    (dsync_ff == D_SYNC && wd_expire && !bypass && cdr_on_line_ff)
    |=> (dsync_ff == D_LOAD && !sync_ok))
    else $error("sync kept after empty window");
endmodule : phy_line_coding_datapath
`default_nettype wire

// ==== core/phy_line_coding_pkg.sv ====
package phy_line_coding_pkg;
  // ==========================================================
  // register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam int unsigned CFG_SPEED_POS = 0;
  localparam int unsigned CFG_BYPASS_POS = 1;
  localparam logic [1:0] CFG_RESET = 2'h1;
  localparam int unsigned ST_START_POS = 0;
  localparam int unsigned ST_END_POS = 1;
  localparam int unsigned ST_CODE_POS = 2;
  localparam int unsigned ST_LOST_POS = 3;
  localparam int unsigned ST_LINE_POS = 4;
  // ==========================================================
  // 5-bit control code words and substituted nibbles
  localparam logic [4:0] CODE_J = 5'h18;
  localparam logic [4:0] CODE_K = 5'h11;
  localparam logic [4:0] CODE_T = 5'h0D;
  localparam logic [4:0] CODE_R = 5'h07;
  localparam logic [4:0] CODE_I = 5'h1F;
  localparam logic [4:0] CODE_H = 5'h04;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned HALF_BIT_PS = 50000;
  localparam int unsigned MARK_HALVES = 4;
  localparam int unsigned LOCK_BITS = 12;
  localparam int unsigned IDLE_ONES_MIN = 25;
  localparam int unsigned ACQ_ONES = 30;
  localparam int unsigned SYNC_WINDOW_NS = 1000000;
  localparam int unsigned SYNC_WINDOW_CYC = SYNC_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  // ==========================================================
  // types
  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } rx_nib_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00, T_SEND_K = 2'b01, T_DATA = 2'b10, T_SEND_R = 2'b11
  } tx_st_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_DATA = 2'b01, M_MARK = 2'b10
  } man_st_t;
  typedef enum logic [1:0] {
    D_LOAD = 2'b00, D_CHECK = 2'b01, D_SYNC = 2'b10
  } dsync_t;
  typedef enum logic [1:0] {
    F_IDLE = 2'b00, F_EXP_K = 2'b01, F_DATA = 2'b10, F_EXP_R = 2'b11
  } frame_t;
endpackage : phy_line_coding_pkg

// ==== test/line_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far-side line receiver: serial bit clock and data
module line_front_end (
  output logic o_clk,
  output logic o_bit
);
  // bit clock stands still low outside frames
  initial begin
    o_clk = 1'b0;
    o_bit = 1'b0;
  end
  // one code word msb first, 125 ns per bit, data set before rise
  task automatic send(input logic [4:0] code);
    for (int i = 4; i >= 0; i--) begin
      o_bit = code[i];
      #62.5 o_clk = 1'b1;
      #62.5 o_clk = 1'b0;
    end
    // released line shows the inverse so stale data never looks valid
    o_bit = ~o_bit;
  endtask : send
endmodule : line_front_end
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import phy_line_coding_pkg::*;
  logic i_ref_clk, i_rst, i_wr, i_rd, i_tx_en, i_squelch_ok, i_eq_settled;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [3:0] i_txd;
  logic o_tx_req, o_tref, o_ltx, o_ltx_en, o_cdr, o_rclk, lclk, lbit;
  logic [9:0] line_hist;
  logic last_tx;
  logic [10:0] lfsr;
  logic [4:0] cw;
  rx_nib_t o_rx, prev;
  rx_nib_t seen[$];
  logic [4:0] q[$];
  int fail_count, checked, k, run;
  logic [4:0] enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
    5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  // ==========================================================
  // design and far side
  phy_line_coding_datapath #(.SYNC_WINDOW_CYCLES(500)) uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_en(i_tx_en), .i_txd(i_txd), .o_tx_req(o_tx_req),
    .o_transmit_ref_clock(o_tref), .o_line_tx(o_ltx),
    .o_line_tx_en(o_ltx_en), .i_line_rx_clk(lclk), .i_line_rx_bit(lbit),
    .i_squelch_ok(i_squelch_ok), .i_eq_settled(i_eq_settled),
    .o_cdr_on_line(o_cdr), .o_recovered_rx_clock(o_rclk), .o_rx(o_rx));
  line_front_end fe (.o_clk(lclk), .o_bit(lbit));
  // ==========================================================
  // clock, line shift history and receive change log
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) line_hist <= {line_hist[8:0], o_ltx};
  always @(negedge i_ref_clk) begin
    if (o_rx !== prev) seen.push_back(o_rx);
    prev = o_rx;
  end
  // ==========================================================
  // checking and bus tasks
  task automatic check(input string w, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 check("reg", o_rdata & m, e);
  endtask : rchk
  // bounded search for a ten-bit pattern on the serial line
  task automatic seek(input logic [9:0] p, input int n);
    k = 0;
    while (line_hist !== p && k < n) begin
      @(negedge i_ref_clk);
      k++;
    end
    check("line", {22'h0, line_hist}, {22'h0, p});
  endtask : seek
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    #600000;
    fail_count++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    {i_rst, i_wr, i_rd, i_tx_en, i_squelch_ok, i_eq_settled} = 6'h20;
    {i_addr, i_wdata, i_txd, fail_count, checked} = '0;
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rchk(CFG_ADDR, 32'hFFFFFFFF, 32'h1);
    rchk(STAT_ADDR, 32'h1F, 32'h8);
    wr(4'h8, 32'hFFFFFFFF);
    rchk(4'h8, 32'hFFFFFFFF, 32'h0);
    // local nibble rate: one request and one clock rise per five cycles
    run = 0;
    k = 0;
    @(negedge i_ref_clk) last_tx = o_rclk;
    repeat (100) @(negedge i_ref_clk) begin
      run += o_tx_req;
      k += (o_rclk && !last_tx);
      last_tx = o_rclk;
    end
    check("req", run, 20);
    check("rclk", k, 20);
    // 100M bypass transmit: raw delimiters, data 0 and idles
    wr(CFG_ADDR, 32'h3);
    @(posedge i_ref_clk);
    i_tx_en <= 1'b1;
    seek(10'h311, 200);
    seek(10'h3DE, 100);
    @(posedge i_ref_clk);
    i_tx_en <= 1'b0;
    seek(10'h1A7, 100);
    seek(10'h3FF, 100);
    // recovery waits for squelch and settled equalizer
    @(posedge i_ref_clk);
    i_squelch_ok <= 1'b1;
    repeat (2) fe.send(CODE_I);
    check("cdr", o_cdr, 1'b0);
    @(posedge i_ref_clk);
    i_eq_settled <= 1'b1;
    repeat (2) fe.send(CODE_I);
    check("cdr", o_cdr, 1'b1);
    // good frame, every data code, bypassed descrambler
    seen.delete();
    q = {CODE_J, CODE_K};
    foreach (enc[i]) q.push_back(enc[i]);
    q = {q, CODE_T, CODE_R, CODE_I, CODE_I};
    foreach (q[i]) fe.send(q[i]);
    repeat (8) @(negedge i_ref_clk);
    check("count", seen.size(), 19);
    check("start", {26'h0, seen[0]}, 32'h25);
    for (int i = 0; i < 16; i++) begin
      check("nib", {26'h0, seen[i + 1]}, 32'h20 + i);
    end
    check("stop", {26'h0, seen[17]}, 32'h20);
    check("end", {26'h0, seen[18]}, 32'h0);
    // bad second start code, then invalid code inside a frame
    seen.delete();
    q = {CODE_J, 5'h00, CODE_I, CODE_I, CODE_J, CODE_K, 5'h00, CODE_T,
      CODE_R, CODE_I, CODE_I};
    foreach (q[i]) fe.send(q[i]);
    run = 0;
    foreach (seen[i]) if (seen[i].er === 1'b1) run++;
    check("rx_er", run >= 2, 1'b1);
    rchk(STAT_ADDR, 32'h7, 32'h5);
    wr(STAT_ADDR, 32'h7);
    rchk(STAT_ADDR, 32'h1F, 32'h10);
    // scrambling on without sync: loss flag stays up
    wr(CFG_ADDR, 32'h1);
    rchk(STAT_ADDR, 32'h8, 32'h8);
    // scrambled idles: sync from idle ones, lost again when they stop
    lfsr = SCR_SEED;
    repeat (10) begin
      for (int i = 4; i >= 0; i--) begin
        lfsr = {lfsr[9:0], lfsr[10] ^ lfsr[8]};
        cw[i] = ~lfsr[0];
      end
      fe.send(cw);
    end
    rchk(STAT_ADDR, 32'h8, 32'h0);
    repeat (600) @(posedge i_ref_clk);
    rchk(STAT_ADDR, 32'h8, 32'h8);
    // 10M: silent gap, manchester toggles, then idle marker
    @(posedge i_ref_clk);
    i_squelch_ok <= 1'b0;
    wr(CFG_ADDR, 32'h0);
    @(posedge i_ref_clk);
    run = 0;
    repeat (300) @(negedge i_ref_clk) run += o_ltx_en;
    check("gap", run, 0);
    @(posedge i_ref_clk);
    i_txd <= 4'hF;
    i_tx_en <= 1'b1;
    repeat (200) @(negedge i_ref_clk);
    run = 0;
    last_tx = o_ltx;
    repeat (125) @(negedge i_ref_clk) begin
      run += (o_ltx !== last_tx);
      last_tx = o_ltx;
    end
    check("cells", run >= 18 && run <= 21, 1'b1);
    @(posedge i_ref_clk);
    i_tx_en <= 1'b0;
    k = 0;
    run = 0;
    while (o_ltx_en !== 1'b0 && k < 500) begin
      @(negedge i_ref_clk);
      if (o_ltx_en) run = o_ltx ? run + 1 : 0;
      k++;
    end
    check("marker", run >= 20 && k < 500, 1'b1);
    // 10M receive: squelch alone switches the loop, twelve bits dropped
    @(posedge i_ref_clk);
    i_eq_settled <= 1'b0;
    i_squelch_ok <= 1'b1;
    repeat (6) @(negedge i_ref_clk);
    check("cdr10", o_cdr, 1'b1);
    seen.delete();
    q = {5'h15, 5'h0A, 5'h15, 5'h0B};
    foreach (q[i]) fe.send(q[i]);
    check("count10", seen.size(), 2);
    check("nib10", {26'h0, seen[0]}, 32'h25);
    check("nib10", {26'h0, seen[1]}, 32'h2D);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
